// [dv/host_model.sv]
`timescale 1ns/1ns
// Host side: one word read of the status register at a time
module host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Bench request
  input  wire logic        req,
  input  wire logic [2:0]  addr,
  output logic      [15:0] word,
  output logic             done,
  // Register read port
  output logic             rd_en,
  output logic      [2:0]  rd_addr,
  input  wire logic [15:0] rd_data
);
  logic [1:0] ph_q; // Read phase
  // Hold address until taken, scramble it after, capture next cycle
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (srst) begin
      rd_en <= 1'b0;
      rd_addr <= 3'h5;
      ph_q <= 2'h0;
    end else if (ph_q == 2'h0 && req) begin
      rd_en <= 1'b1; // Prompt request
      rd_addr <= addr;
      ph_q <= 2'h1;
    end else if (ph_q == 2'h1) begin
      rd_en <= 1'b0;
      rd_addr <= ~rd_addr;
      ph_q <= 2'h2;
    end else if (ph_q == 2'h2) begin
      word <= rd_data;
      done <= 1'b1;
      ph_q <= 2'h0;
    end
  end
endmodule

// [dv/selftest_fatal_error_report_tb.sv]
`timescale 1ns/1ns
// Bench for self-test sequencing and fatal code posting
module selftest_fatal_error_report_tb;
  logic        clk, srst, bus_init, dc_low_line, board_reset_switch;
  logic        host_init, p1_done, p1_pass, drive_resp, probe_done;
  logic        p2_done, p2_pass, req, done, rd_en, fault_indicator;
  logic        selftest_failed, fatal_posted, ce;
  logic [18:0] fault_evt;
  logic [2:0]  addr, rd_addr, a;
  logic [15:0] rd_data, word;
  logic [31:0] lfsr_q;
  int          n_fail, tests_run, k;

  selftest_fatal_error_report u_selftest_fatal_error_report (.clk, .srst,
    .ce, .bus_init, .dc_low_line, .board_reset_switch, .host_init,
    .p1_done, .p1_pass, .drive_resp, .probe_done, .p2_done, .p2_pass,
    .fault_evt, .rd_addr, .rd_en, .rd_data, .fault_indicator,
    .selftest_failed, .fatal_posted);
  host_model u_host_model (.clk, .srst, .req, .addr, .word, .done, .rd_en,
    .rd_addr, .rd_data);

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Next pseudo-random value
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected code for each fault strobe bit
  function automatic logic [7:0] code_of(input int i);
    logic [7:0] t [19];
    t = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h13,
      8'h40, 8'h43, 8'h45, 8'h46, 8'h47, 8'h48};
    return t[i];
  endfunction

  task automatic step();
    @(posedge clk);
    #5;
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Status read through the host model, bounded wait
  task automatic rd(input logic [2:0] ad, input logic [15:0] exp,
                    input string m);
    step();
    addr = ad;
    req = 1'b1;
    for (k = 0; k < 10 && done !== 1'b1; k++) step();
    req = 1'b0;
    if (done !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    chk(word, exp, m);
  endtask

  // Phase one passes, then drive probe
  task automatic boot(input logic resp);
    p1_done = 1'b1;
    p1_pass = 1'b1;
    step();
    p1_done = 1'b0;
    probe_done = 1'b1;
    drive_resp = resp;
    step();
    probe_done = 1'b0;
  endtask

  // Raise one restart source for three cycles
  task automatic restart(input int s);
    case (s)
      0: bus_init = 1'b1;
      1: dc_low_line = 1'b1;
      default: board_reset_switch = 1'b1;
    endcase
    repeat (3) step();
    {bus_init, dc_low_line, board_reset_switch} = 3'h0;
    repeat (6) step();
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end

  // Main sequence
  initial begin
    {srst, bus_init, dc_low_line, board_reset_switch, host_init} = 5'h1F;
    {bus_init, dc_low_line, board_reset_switch, host_init} = 4'h0;
    {p1_done, p1_pass, drive_resp, probe_done, p2_done, p2_pass} = 6'h0;
    {req, addr, fault_evt} = '0;
    lfsr_q = 32'hFCD1;
    ce = 1'b1;
    n_fail = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    #5;
    srst = 1'b0;
    repeat (2) step();
    chk({15'h0, fault_indicator}, 16'h1, "lit at start");
    rd(3'h2, 16'h0, "reset word");
    ce = 1'b0;
    p1_done = 1'b1;
    p1_pass = 1'b1;
    repeat (3) step();
    chk({15'h0, fault_indicator}, 16'h1, "frozen");
    ce = 1'b1;
    boot(1'b1);
    for (k = 0; k < 10 && fault_indicator !== 1'b0; k++) step();
    chk({15'h0, fault_indicator}, 16'h0, "dark");
    chk({15'h0, selftest_failed}, 16'h0, "no self-test fail");
    host_init = 1'b1;
    repeat (3) step();
    host_init = 1'b0;
    repeat (4) step();
    p2_done = 1'b1;
    step();
    p2_done = 1'b0;
    repeat (4) step();
    chk({15'h0, fault_indicator}, 16'h0, "phase two dark");
    rd(3'h2, 16'h000C, "phase two code");
    for (int i = 0; i < 19; i++) begin
      restart(i % 3);
      chk({15'h0, fault_indicator}, 16'h1, "relit");
      rd(3'h2, 16'h0, "cleared");
      boot(i != 5);
      lfsr_q = lfsr_next(lfsr_q);
      fault_evt = (lfsr_q[18:0] << (i + 1)) | (19'h1 << i);
      step();
      fault_evt = '0;
      step();
      chk({15'h0, fatal_posted}, 16'h1, "posted");
      rd(3'h2, {8'h00, code_of(i)}, "code");
      fault_evt = 19'h1 << (i == 0);
      step();
      fault_evt = '0;
      rd(3'h2, {8'h00, code_of(i)}, "held");
      a = lfsr_q[21:19];
      if (a == 3'h2) begin
        a = 3'h3;
      end
      rd(a, 16'h0, "unmapped");
    end
    end_sim();
  end
endmodule

// [verilog/selftest_consts.svh]
`ifndef SELFTEST_CONSTS_SVH
`define SELFTEST_CONSTS_SVH

// Status word location on the host bus
`define STATUS_WORD_OFFSET 3'h2
// Clock rate and indicator deadline
`define CLK_HZ             20000000
`define FAULT_DEADLINE_S   2
`define FAULT_DEADLINE_CYC (`CLK_HZ * `FAULT_DEADLINE_S)
// Flash half period in seconds times ten
`define FLASH_HALF_DS      2
`define FLASH_HALF_CYC     (`CLK_HZ / 10 * `FLASH_HALF_DS)
// Fatal error codes, low byte of status word
`define FC_NO_INFO     8'h00
`define FC_PKT_READ    8'h01
`define FC_PKT_WRITE   8'h02
`define FC_RAM         8'h04
`define FC_CHECKSUM    8'h05
`define FC_RING_READ   8'h06
`define FC_RING_WRITE  8'h07
`define FC_HOST_TMO    8'h09
`define FC_CMD_OVER    8'h0A
`define FC_DMA         8'h0B
`define FC_CTRL_FATAL  8'h0C
`define FC_BAD_CONN    8'h0E
`define FC_INIT_SEQ    8'h13
`define FC_NOT_READY   8'h40
`define FC_RCT_WRITE   8'h43
`define FC_FORMAT      8'h45
`define FC_WPROT       8'h46
`define FC_FCT_WRITE   8'h47
`define FC_BAD_REQ     8'h48
// Fault source vector width and status high byte reset value
`define NUM_FAULTS     19
`define STAT_HI_RESET  8'h00

`endif

// [verilog/selftest_fatal_error_report.sv]
`timescale 1ns/1ns
`include "selftest_consts.svh"

// Contract
// R01 - Fault indicator on when internal tests start
// R02 - Indicator off after phase one passes
// R03 - Indicator must be off within 2 s
// R04 - Phase one runs right after power-up
// R05 - Probe drives; flash when none answer
// R06 - Phase two runs at host initialization
// R07 - Host-init errors go to status word
// R08 - Fatal code posted in status low byte
// R09 - Packet codes 0, 1, 2
// R10 - Self-test codes 4, 5, octal 14
// R11 - Ring envelope codes 6, 7
// R12 - Host timeout 9, command overrun A
// R13 - Codes octal 13, 16, 23
// R14 - Format codes 40 through 48
// R15 - Restart self-test at every bus init
// R16 - Hold fatal code until next init
module selftest_fatal_error_report (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // Board reset sources and host init (asynchronous pins)
  input  wire logic        bus_init,
  input  wire logic        dc_low_line,
  input  wire logic        board_reset_switch,
  input  wire logic        host_init,
  // Firmware test results, same clock
  input  wire logic        p1_done,
  input  wire logic        p1_pass,
  input  wire logic        drive_resp,
  input  wire logic        probe_done,
  input  wire logic        p2_done,
  input  wire logic        p2_pass,
  // Fatal event strobes, one bit per code
  input  wire logic [18:0] fault_evt,
  // Host read of status word
  input  wire logic [2:0]  rd_addr,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  // Indicator and status
  output logic             fault_indicator,
  output logic             selftest_failed,
  output logic             fatal_posted
);

  // Synchronisers for pin inputs
  logic [1:0] init_s_q;
  logic [1:0] dcl_s_q;
  logic [1:0] sw_s_q;
  logic [1:0] hinit_s_q;
  logic       init_prev_q;       // Previous reset level
  logic       hinit_prev_q;      // Previous host init level
  // Sequencer
  selftest_pkg::seq_state_t st_q;
  selftest_pkg::seq_state_t st_d;
  logic [25:0] dl_cnt_q;         // Deadline counter
  logic [22:0] fl_cnt_q;         // Flash half period counter
  logic        flash_q;          // Flash phase
  logic        flashing_q;       // No drive answered
  logic [15:0] port_status_word_q;
  logic        led_q;
  logic        p1_pass_seen;     // Phase one passed

  // Reset level after synchronisation
  wire init_lvl   = init_s_q[1] | dcl_s_q[1] | sw_s_q[1];
  wire init_rise  = init_lvl & ~init_prev_q;
  wire hinit_rise = hinit_s_q[1] & ~hinit_prev_q;
  wire deadline   = (dl_cnt_q == 26'(`FAULT_DEADLINE_CYC));

  // Fault code table, one entry per event bit
  logic [7:0] code_tab [0:18];
  assign code_tab[0]  = `FC_NO_INFO;
  assign code_tab[1]  = `FC_PKT_READ;
  assign code_tab[2]  = `FC_PKT_WRITE;
  assign code_tab[3]  = `FC_RAM;
  assign code_tab[4]  = `FC_CHECKSUM;
  assign code_tab[5]  = `FC_RING_READ;
  assign code_tab[6]  = `FC_RING_WRITE;
  assign code_tab[7]  = `FC_HOST_TMO;
  assign code_tab[8]  = `FC_CMD_OVER;
  assign code_tab[9]  = `FC_DMA;
  assign code_tab[10] = `FC_CTRL_FATAL;
  assign code_tab[11] = `FC_BAD_CONN;
  assign code_tab[12] = `FC_INIT_SEQ;
  assign code_tab[13] = `FC_NOT_READY;
  assign code_tab[14] = `FC_RCT_WRITE;
  assign code_tab[15] = `FC_FORMAT;
  assign code_tab[16] = `FC_WPROT;
  assign code_tab[17] = `FC_FCT_WRITE;
  assign code_tab[18] = `FC_BAD_REQ;

  // Priority pick: lowest set bit wins
  logic [7:0] pick [0:19];
  assign pick[19] = 8'h00;
  genvar gi;
  generate
    for (gi = 0; gi < 19; gi++) begin : g_pick
      assign pick[gi] = fault_evt[gi] ? code_tab[gi] : pick[gi+1];
    end
  endgenerate
  wire any_fault = |fault_evt;
  // Phase two failure reports through the status word
  wire p2_fail   = (st_q == selftest_pkg::ST_PHASE2) & p2_done &
                   ~p2_pass; // [R07]
  wire [7:0] post_code = any_fault ? pick[0] : `FC_CTRL_FATAL; // [R07]
  // First fault only, code held until init
  wire post_now  = (any_fault | p2_fail) & ~fatal_posted &
                   (st_q != selftest_pkg::ST_IDLE); // [R08] [R16]
  wire addr_hit  = rd_en & (rd_addr == `STATUS_WORD_OFFSET);

  // Input synchronisers
  always_ff @(posedge clk) begin
    if (ce) begin
      init_s_q  <= {init_s_q[0], bus_init};
      dcl_s_q   <= {dcl_s_q[0], dc_low_line};
      sw_s_q    <= {sw_s_q[0], board_reset_switch};
      hinit_s_q <= {hinit_s_q[0], host_init};
    end
  end

  // Next state of sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      selftest_pkg::ST_IDLE:   st_d = selftest_pkg::ST_PHASE1; // [R04]
      selftest_pkg::ST_PHASE1: begin
        if (p1_done & p1_pass) st_d = selftest_pkg::ST_PROBE;
        else if (p1_done) st_d = selftest_pkg::ST_FATAL;
      end
      selftest_pkg::ST_PROBE:  begin
        if (probe_done) st_d = selftest_pkg::ST_READY;
      end
      selftest_pkg::ST_READY:  begin
        if (hinit_rise) st_d = selftest_pkg::ST_PHASE2; // [R06]
      end
      selftest_pkg::ST_PHASE2: begin
        if (p2_done & p2_pass) st_d = selftest_pkg::ST_RUN;
        else if (p2_done) st_d = selftest_pkg::ST_FATAL; // [R07]
      end
      selftest_pkg::ST_RUN:    st_d = st_q;
      selftest_pkg::ST_FATAL:  st_d = st_q;
      default:                 st_d = selftest_pkg::ST_IDLE;
    endcase
    if (any_fault & (st_q != selftest_pkg::ST_IDLE))
      st_d = selftest_pkg::ST_FATAL;
  end

  // Sequencer and deadline counter
  always_ff @(posedge clk) begin
    if (srst | (ce & init_rise)) begin // [R15]
      st_q     <= selftest_pkg::ST_IDLE;
      dl_cnt_q <= 26'h0;
    end else if (ce) begin
      st_q <= st_d;
      if (!deadline)
        dl_cnt_q <= dl_cnt_q + 26'h1;
    end
  end

  // Reset edge trackers
  always_ff @(posedge clk) begin
    if (srst) begin
      init_prev_q  <= 1'b0;
      hinit_prev_q <= 1'b0;
    end else if (ce) begin
      init_prev_q  <= init_lvl;
      hinit_prev_q <= hinit_s_q[1];
    end
  end

  // Flash timing
  always_ff @(posedge clk) begin
    if (srst | (ce & init_rise)) begin
      fl_cnt_q   <= 23'h0;
      flash_q    <= 1'b0;
      flashing_q <= 1'b0;
    end else if (ce) begin
      if (st_q == selftest_pkg::ST_PROBE && probe_done && !drive_resp)
        flashing_q <= 1'b1; // [R05]
      if (fl_cnt_q == 23'(`FLASH_HALF_CYC - 1)) begin
        fl_cnt_q <= 23'h0;
        flash_q  <= ~flash_q;
      end else begin
        fl_cnt_q <= fl_cnt_q + 23'h1;
      end
    end
  end

  // Indicator drive
  always_ff @(posedge clk) begin
    if (srst) begin
      led_q <= 1'b1;
    end else if (ce) begin
      if (init_lvl || st_q == selftest_pkg::ST_IDLE ||
          st_q == selftest_pkg::ST_PHASE1)
        led_q <= 1'b1; // [R01]
      else if (flashing_q)
        led_q <= flash_q; // [R05]
      else if (st_q == selftest_pkg::ST_FATAL && !p1_pass_seen)
        led_q <= 1'b1;
      else
        led_q <= 1'b0; // [R02] [R07]
    end
  end

  // Phase one success memory
  always_ff @(posedge clk) begin
    if (srst | (ce & init_rise))
      p1_pass_seen <= 1'b0;
    else if (ce && st_q == selftest_pkg::ST_PHASE1 && p1_done && p1_pass)
      p1_pass_seen <= 1'b1;
  end

  // Status word and flags
  always_ff @(posedge clk) begin
    if (srst | (ce & init_rise)) begin // [R16]
      port_status_word_q <= {`STAT_HI_RESET, `FC_NO_INFO};
      fatal_posted       <= 1'b0;
      selftest_failed    <= 1'b0;
    end else if (ce) begin
      if (post_now) begin
        port_status_word_q <= {`STAT_HI_RESET, post_code}; // [R08] [R09]
        fatal_posted       <= 1'b1; // [R10] [R11] [R12] [R13] [R14]
      end
      if (deadline && led_q && !flashing_q)
        selftest_failed <= 1'b1; // [R03]
    end
  end

  // Outputs from flip-flops
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data         <= 16'h0000;
      fault_indicator <= 1'b1;
    end else if (ce) begin
      rd_data         <= addr_hit ? port_status_word_q : 16'h0000;
      fault_indicator <= led_q;
    end
  end

  // Posted code never changes until an init
  property p_hold_code;
    @(posedge clk) disable iff (srst)
      (fatal_posted && ce && !init_rise) |=>
        (port_status_word_q == $past(port_status_word_q));
  endproperty
  a_hold_code: assert property (p_hold_code) // [R16]
    else $error("posted fatal code changed");

  // Bus init returns sequencer to the start
  property p_restart;
    @(posedge clk) disable iff (srst)
      (ce && init_rise) |=> (st_q == selftest_pkg::ST_IDLE);
  endproperty
  a_restart: assert property (p_restart) // [R15]
    else $error("bus init did not restart self-test");

  // Indicator lit while phase one runs
  sequence s_in_p1;
    ce && st_q == selftest_pkg::ST_PHASE1 && !init_lvl;
  endsequence
  property p_led_p1;
    @(posedge clk) disable iff (srst)
      s_in_p1 ##1 ce |=> fault_indicator;
  endproperty
  a_led_p1: assert property (p_led_p1) // [R01]
    else $error("indicator dark during phase one");

  // A fault event posts its code one cycle later
  property p_post;
    @(posedge clk) disable iff (srst)
      (post_now && ce && !init_rise) |=>
        (fatal_posted && port_status_word_q[7:0] == $past(post_code));
  endproperty
  a_post: assert property (p_post) // [R08]
    else $error("fatal code not posted");

  // RAM fault alone yields code 4
  property p_ram_code;
    @(posedge clk) disable iff (srst)
      (post_now && ce && !init_rise && fault_evt == 19'h00008) |=>
        (port_status_word_q[7:0] == 8'h04);
  endproperty
  a_ram_code: assert property (p_ram_code) // [R10]
    else $error("RAM fault code wrong");

  // Host timeout alone yields code 9
  property p_tmo_code;
    @(posedge clk) disable iff (srst)
      (post_now && ce && !init_rise && fault_evt == 19'h00080) |=>
        (port_status_word_q[7:0] == 8'h09);
  endproperty
  a_tmo_code: assert property (p_tmo_code) // [R12]
    else $error("host timeout code wrong");

  // Host init in ready starts phase two
  property p_phase2;
    @(posedge clk) disable iff (srst)
      (ce && st_q == selftest_pkg::ST_READY && hinit_rise && !init_rise &&
       !any_fault) |=> (st_q == selftest_pkg::ST_PHASE2);
  endproperty
  a_phase2: assert property (p_phase2) // [R06]
    else $error("phase two not entered");

  // Pass of probe with drive answer darkens indicator
  property p_led_off;
    @(posedge clk) disable iff (srst)
      (ce && st_q == selftest_pkg::ST_READY && !flashing_q && !init_lvl)
        ##1 ce |=> !fault_indicator;
  endproperty
  a_led_off: assert property (p_led_off) // [R02]
    else $error("indicator lit after passing phase one");

  // Status word reads back on the bus
  property p_read;
    @(posedge clk) disable iff (srst)
      (ce && addr_hit) |=> (rd_data == $past(port_status_word_q));
  endproperty
  a_read: assert property (p_read) // [R07]
    else $error("status word read wrong");

endmodule

// [verilog/selftest_pkg.sv]
package selftest_pkg;
  // Self-test sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PHASE1,
    ST_PROBE,
    ST_READY,
    ST_PHASE2,
    ST_RUN,
    ST_FATAL
  } seq_state_t;
endpackage
